// ### shared/cid_pkg.sv
package cid_pkg;

  localparam int ID_W   = 11;
  localparam int FC_W   = 4;
  localparam int NODE_W = 7;

  localparam logic [FC_W-1:0] FC_NMT     = 4'h0;
  localparam logic [FC_W-1:0] FC_SYNC    = 4'h1;
  localparam logic [FC_W-1:0] FC_TIME    = 4'h2;
  localparam logic [FC_W-1:0] FC_TPDO1   = 4'h3;
  localparam logic [FC_W-1:0] FC_RPDO1   = 4'h4;
  localparam logic [FC_W-1:0] FC_TPDO2   = 4'h5;
  localparam logic [FC_W-1:0] FC_TPDO3   = 4'h7;
  localparam logic [FC_W-1:0] FC_TPDO4   = 4'h9;
  localparam logic [FC_W-1:0] FC_SDO_TX  = 4'hb;
  localparam logic [FC_W-1:0] FC_SDO_RX  = 4'hc;
  localparam logic [NODE_W-1:0] NODE_NONE = 7'h00;

  localparam logic [3:0] SDO_DLC     = 4'h8;
  localparam logic [3:0] TPDO_DLC    = 4'h2;

  localparam logic [7:0] CMD_DL4    = 8'h23;
  localparam logic [7:0] CMD_DL2    = 8'h2b;
  localparam logic [7:0] CMD_DL1    = 8'h2f;
  localparam logic [7:0] CMD_UL     = 8'h40;
  localparam logic [7:0] RES_DL_OK  = 8'h60;
  localparam logic [7:0] RES_UL4    = 8'h43;
  localparam logic [7:0] RES_UL2    = 8'h4b;
  localparam logic [7:0] RES_UL1    = 8'h4f;
  localparam logic [7:0] RES_ERR    = 8'h80;

  localparam logic [31:0] ABORT_CMD    = 32'h0504_0001;
  localparam logic [31:0] ABORT_WO     = 32'h0601_0001;
  localparam logic [31:0] ABORT_RO     = 32'h0601_0002;
  localparam logic [31:0] ABORT_NO_OBJ = 32'h0602_0000;

  localparam logic [7:0] NMT_START    = 8'h01;
  localparam logic [7:0] NMT_STOP     = 8'h02;
  localparam logic [7:0] NMT_PREOP    = 8'h80;
  localparam logic [7:0] NMT_RST_NODE = 8'h81;
  localparam logic [7:0] NMT_RST_COMM = 8'h82;

  localparam logic [1:0] ST_PREOP = 2'h0;
  localparam logic [1:0] ST_OPER  = 2'h1;
  localparam logic [1:0] ST_STOP  = 2'h2;

  // Object table: entry 0 control, 1 status, 2 mode, 3 target.
  localparam int OBJ_N = 4;
  localparam logic [1:0] OBJ_STATUS = 2'h1;
  localparam logic [15:0] OBJ_INDEX [OBJ_N] = '{16'h6040, 16'h6041, 16'h6060, 16'h607a};
  localparam logic [7:0]  OBJ_SUB   = 8'h00;
  localparam logic [7:0]  OBJ_UPRES [OBJ_N] = '{RES_UL2, RES_UL2, RES_UL1, RES_UL4};
  localparam logic [31:0] OBJ_MASK  [OBJ_N] = '{32'h0000_ffff, 32'h0000_ffff, 32'h0000_00ff, 32'hffff_ffff};
  localparam logic [OBJ_N-1:0] OBJ_RD    = 4'b0111;
  localparam logic [OBJ_N-1:0] OBJ_WR    = 4'b1101;
  localparam logic [OBJ_N-1:0] OBJ_MAP   = 4'b0010;
  localparam logic [OBJ_N-1:0] OBJ_STORE = 4'b0000;
  localparam logic [31:0] OBJ_RESET = 32'h0000_0000;

  typedef enum logic [1:0] {NMT_S_PREOP, NMT_S_OPER, NMT_S_STOP} cid_nmt_e;
  typedef enum logic [1:0] {SDO_IDLE, SDO_READ, SDO_SEND} cid_sdo_e;

endpackage : cid_pkg

// ### shared/cid_od_if.sv
`timescale 1ns/1ps
`default_nettype none
interface cid_od_if;
  logic        wr_en;
  logic [1:0]  wr_sel;
  logic [31:0] wr_data;
  logic        rd_en;
  logic [1:0]  rd_sel;
  logic [31:0] rd_data;
  logic [31:0] val [4];

  modport master (output wr_en, wr_sel, wr_data, rd_en, rd_sel, input rd_data, val);
  modport store  (input wr_en, wr_sel, wr_data, rd_en, rd_sel, output rd_data, val);
endinterface : cid_od_if
`default_nettype wire

// ### rtl/cid_od_store.sv
`timescale 1ns/1ps
`default_nettype none
module cid_od_store
  import cid_pkg::*;
(
  input  wire logic  clk_in,
  input  wire logic  srst_in,
  cid_od_if.store    od
);

  logic [31:0] obj_q [OBJ_N];
  logic [31:0] obj_d [OBJ_N];
  logic [31:0] rd_q;
  logic [31:0] rd_d;

  genvar gi;
  generate
    for (gi = 0; gi < OBJ_N; gi++)
    begin : g_obj
      // Only writable objects take data; the status entry stays at reset.
      always_comb
      begin
        obj_d[gi] = obj_q[gi];
        if (od.wr_en && od.wr_sel == 2'(gi) && OBJ_WR[gi])
          obj_d[gi] = od.wr_data & OBJ_MASK[gi];
      end
      always_ff @(posedge clk_in)
      begin
        if (srst_in)
          obj_q[gi] <= OBJ_RESET;
        else
          obj_q[gi] <= obj_d[gi];
      end
      assign od.val[gi] = obj_q[gi];
    end
  endgenerate

  always_comb
  begin
    rd_d = rd_q;
    if (od.rd_en)
      rd_d = obj_q[od.rd_sel];
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      rd_q <= OBJ_RESET;
    else
      rd_q <= rd_d;
  end

  assign od.rd_data = rd_q;

endmodule : cid_od_store
`default_nettype wire

// ### rtl/cid_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module cid_decoder
  import cid_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        srst_in,
  input  wire logic [6:0]  station_in,
  input  wire logic        rx_valid_in,
  input  wire logic [10:0] rx_id_in,
  input  wire logic [3:0]  rx_dlc_in,
  input  wire logic [63:0] rx_data_in,
  output logic             tx_valid_out,
  output logic [10:0]      tx_id_out,
  output logic [3:0]       tx_dlc_out,
  output logic [63:0]      tx_data_out,
  input  wire logic        tx_ready_in,
  input  wire logic [15:0] drive_status_in,
  input  wire logic [1:0]  tpdo_map_sel_in,
  output logic             map_fault_out,
  output logic [15:0]      drive_control_word_out,
  output logic [7:0]       operating_mode_select_out,
  output logic [31:0]      target_position_value_out,
  output logic             rpdo_valid_out,
  output logic [3:0]       rpdo_dlc_out,
  output logic [63:0]      rpdo_data_out,
  output logic             sync_pulse_out,
  output logic             time_pulse_out,
  output logic [1:0]       nmt_state_out,
  output logic             reset_node_out,
  output logic             reset_comm_out,
  output logic             nv_store_out,
  output logic [1:0]       nv_store_sel_out,
  output logic [31:0]      nv_store_data_out,
  output logic [6:0]       station_out
);

  cid_od_if od ();

  cid_od_store u_store (
    .clk_in  (clk_in),
    .srst_in (srst_in),
    .od      (od)
  );

  // Station switches are off-clock pins; three stages, accepted when the last two agree.
  logic [6:0]  st1_q, st2_q, st3_q, node_q, node_d;
  cid_nmt_e    nmt_q, nmt_d;
  cid_sdo_e    sdo_q, sdo_d;
  logic [63:0] rep_q, rep_d;
  logic [1:0]  rsel_q, rsel_d;
  logic [7:0]  rcmd_q, rcmd_d;
  logic        tpdo_q, tpdo_d;
  logic        txv_q, txv_d;
  logic [10:0] txid_q, txid_d;
  logic [3:0]  txdlc_q, txdlc_d;
  logic [63:0] txdat_q, txdat_d;
  logic        rpv_q, rpv_d, syn_q, syn_d, tim_q, tim_d, rn_q, rn_d, rc_q, rc_d;
  logic [3:0]  rpdlc_q, rpdlc_d;
  logic [63:0] rpdat_q, rpdat_d;
  logic        nvs_q, nvs_d;
  logic [1:0]  nvsel_q, nvsel_d;
  logic [31:0] nvdat_q, nvdat_d;

  logic [FC_W-1:0]   fc;
  logic [NODE_W-1:0] nd;
  logic        node_ok, addressed, is_nmt, is_sync, is_time, is_sdo, is_rpdo;
  logic        nmt_hit, obj_hit, can_load, pick_sdo;
  logic [1:0]  obj_sel;
  logic [7:0]  cmd, tgt;
  logic [15:0] idx, status_word;
  logic [31:0] dl_val;
  logic [10:0] sdo_id, tpdo_id;
  logic [1:0]  nmt_code;

  always_comb
  begin
    fc = rx_id_in[ID_W-1:NODE_W];
    nd = rx_id_in[NODE_W-1:0];
    node_ok = node_q != NODE_NONE;
    addressed = node_ok && nd == node_q;
    is_nmt  = rx_valid_in && rx_id_in == {FC_NMT, NODE_NONE};
    is_sync = rx_valid_in && rx_id_in == {FC_SYNC, NODE_NONE};
    is_time = rx_valid_in && rx_id_in == {FC_TIME, NODE_NONE};
    is_sdo  = rx_valid_in && fc == FC_SDO_RX && addressed;
    is_rpdo = rx_valid_in && fc == FC_RPDO1 && addressed;
    cmd = rx_data_in[7:0];
    tgt = rx_data_in[15:8];
    idx = rx_data_in[23:8];
    nmt_hit = tgt == 8'h00 || (node_ok && tgt == {1'b0, node_q});
    obj_hit = 1'b0;
    obj_sel = 2'h0;
    for (int i = 0; i < OBJ_N; i++)
    begin
      if (idx == OBJ_INDEX[i] && rx_data_in[31:24] == OBJ_SUB)
      begin
        obj_hit = 1'b1;
        obj_sel = 2'(i);
      end
    end
    unique case (cmd)
      CMD_DL1: dl_val = {24'h000000, rx_data_in[39:32]};
      CMD_DL2: dl_val = {16'h0000, rx_data_in[47:32]};
      default: dl_val = rx_data_in[63:32];
    endcase
    unique case (nmt_q)
      NMT_S_OPER: nmt_code = ST_OPER;
      NMT_S_STOP: nmt_code = ST_STOP;
      NMT_S_PREOP: nmt_code = ST_PREOP;
      default: nmt_code = ST_PREOP;
    endcase
    status_word = {drive_status_in[15:2], nmt_code};
    sdo_id  = {FC_SDO_TX, node_q};
    tpdo_id = {FC_TPDO1, node_q};
  end

  // Next state of the node, the service channel and the object store ports.
  always_comb
  begin
    node_d = (st2_q == st3_q) ? st3_q : node_q;
    nmt_d = nmt_q;
    rn_d = 1'b0;
    rc_d = 1'b0;
    syn_d = is_sync;
    tim_d = is_time;
    rpv_d = 1'b0;
    rpdlc_d = rpdlc_q;
    rpdat_d = rpdat_q;
    sdo_d = sdo_q;
    rep_d = rep_q;
    rsel_d = rsel_q;
    rcmd_d = rcmd_q;
    nvs_d = 1'b0;
    nvsel_d = nvsel_q;
    nvdat_d = nvdat_q;
    od.wr_en = 1'b0;
    od.wr_sel = obj_sel;
    od.wr_data = dl_val;
    od.rd_en = 1'b0;
    od.rd_sel = obj_sel;
    if (is_nmt && nmt_hit)
    begin
      unique case (cmd)
        NMT_START: nmt_d = NMT_S_OPER;
        NMT_STOP:  nmt_d = NMT_S_STOP;
        NMT_PREOP: nmt_d = NMT_S_PREOP;
        NMT_RST_NODE:
        begin
          nmt_d = NMT_S_PREOP;
          rn_d = 1'b1;
        end
        NMT_RST_COMM:
        begin
          nmt_d = NMT_S_PREOP;
          rc_d = 1'b1;
        end
        default: nmt_d = nmt_q;
      endcase
    end
    // Received process data is passed on raw and never answered.
    if (is_rpdo && nmt_q == NMT_S_OPER)
    begin
      rpv_d = 1'b1;
      rpdlc_d = rx_dlc_in;
      rpdat_d = rx_data_in;
    end
    unique case (sdo_q)
      SDO_IDLE:
      begin
        // A stopped node answers module control only.
        if (is_sdo && nmt_q != NMT_S_STOP)
        begin
          sdo_d = SDO_SEND;
          rep_d = {32'h0000_0000, rx_data_in[31:24], idx, RES_DL_OK};
          if (!obj_hit)
            rep_d = {ABORT_NO_OBJ, rx_data_in[31:8], RES_ERR};
          else if (cmd == CMD_UL)
          begin
            if (!OBJ_RD[obj_sel])
              rep_d = {ABORT_WO, rx_data_in[31:8], RES_ERR};
            else if (obj_sel == OBJ_STATUS)
              rep_d = {16'h0000, status_word, rx_data_in[31:8], OBJ_UPRES[obj_sel]};
            else
            begin
              od.rd_en = 1'b1;
              rsel_d = obj_sel;
              rcmd_d = OBJ_UPRES[obj_sel];
              rep_d = {32'h0000_0000, rx_data_in[31:8], RES_UL4};
              sdo_d = SDO_READ;
            end
          end
          else if (cmd == CMD_DL1 || cmd == CMD_DL2 || cmd == CMD_DL4)
          begin
            if (!OBJ_WR[obj_sel])
              rep_d = {ABORT_RO, rx_data_in[31:8], RES_ERR};
            else
            begin
              od.wr_en = 1'b1;
              if (OBJ_STORE[obj_sel])
              begin
                nvs_d = 1'b1;
                nvsel_d = obj_sel;
                nvdat_d = dl_val & OBJ_MASK[obj_sel];
              end
            end
          end
          else
            rep_d = {ABORT_CMD, rx_data_in[31:8], RES_ERR};
        end
      end
      SDO_READ:
      begin
        rep_d = {od.rd_data & OBJ_MASK[rsel_q], rep_q[31:8], rcmd_q};
        sdo_d = SDO_SEND;
      end
      SDO_SEND:
      begin
        if (can_load && pick_sdo)
          sdo_d = SDO_IDLE;
      end
    endcase
  end

  // Transmit slot: one frame register, refilled as soon as the controller takes it.
  always_comb
  begin
    can_load = !txv_q || tx_ready_in;
    // The lower identifier reaches its first 0 bit earlier, and that dominant bit wins arbitration.
    pick_sdo = sdo_q == SDO_SEND && !(tpdo_q && tpdo_id < sdo_id);
    tpdo_d = tpdo_q;
    txv_d = txv_q && !tx_ready_in;
    txid_d = txid_q;
    txdlc_d = txdlc_q;
    txdat_d = txdat_q;
    if (can_load && pick_sdo)
    begin
      txv_d = 1'b1;
      txid_d = sdo_id;
      txdlc_d = SDO_DLC;
      txdat_d = rep_q;
    end
    else if (can_load && tpdo_q)
    begin
      txv_d = 1'b1;
      txid_d = tpdo_id;
      txdlc_d = TPDO_DLC;
      txdat_d = {48'h0000_0000_0000, status_word};
      tpdo_d = 1'b0;
    end
    if (nmt_q != NMT_S_OPER)
      tpdo_d = 1'b0;
    else if (is_sync && OBJ_MAP[tpdo_map_sel_in] && node_ok)
      tpdo_d = 1'b1;
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      st1_q <= NODE_NONE;
      st2_q <= NODE_NONE;
      st3_q <= NODE_NONE;
      node_q <= NODE_NONE;
      nmt_q <= NMT_S_PREOP;
      sdo_q <= SDO_IDLE;
      rep_q <= 64'h0000_0000_0000_0000;
      rsel_q <= 2'h0;
      rcmd_q <= 8'h00;
      tpdo_q <= 1'b0;
      txv_q <= 1'b0;
      txid_q <= 11'h000;
      txdlc_q <= 4'h0;
      txdat_q <= 64'h0000_0000_0000_0000;
      rpv_q <= 1'b0;
      rpdlc_q <= 4'h0;
      rpdat_q <= 64'h0000_0000_0000_0000;
      syn_q <= 1'b0;
      tim_q <= 1'b0;
      rn_q <= 1'b0;
      rc_q <= 1'b0;
      nvs_q <= 1'b0;
      nvsel_q <= 2'h0;
      nvdat_q <= 32'h0000_0000;
    end
    else
    begin
      st1_q <= station_in;
      st2_q <= st1_q;
      st3_q <= st2_q;
      node_q <= node_d;
      nmt_q <= nmt_d;
      sdo_q <= sdo_d;
      rep_q <= rep_d;
      rsel_q <= rsel_d;
      rcmd_q <= rcmd_d;
      tpdo_q <= tpdo_d;
      txv_q <= txv_d;
      txid_q <= txid_d;
      txdlc_q <= txdlc_d;
      txdat_q <= txdat_d;
      rpv_q <= rpv_d;
      rpdlc_q <= rpdlc_d;
      rpdat_q <= rpdat_d;
      syn_q <= syn_d;
      tim_q <= tim_d;
      rn_q <= rn_d;
      rc_q <= rc_d;
      nvs_q <= nvs_d;
      nvsel_q <= nvsel_d;
      nvdat_q <= nvdat_d;
    end
  end

  assign tx_valid_out = txv_q;
  assign tx_id_out = txid_q;
  assign tx_dlc_out = txdlc_q;
  assign tx_data_out = txdat_q;
  assign map_fault_out = !OBJ_MAP[tpdo_map_sel_in];
  assign drive_control_word_out = od.val[0][15:0];
  assign operating_mode_select_out = od.val[2][7:0];
  assign target_position_value_out = od.val[3];
  assign rpdo_valid_out = rpv_q;
  assign rpdo_dlc_out = rpdlc_q;
  assign rpdo_data_out = rpdat_q;
  assign sync_pulse_out = syn_q;
  assign time_pulse_out = tim_q;
  assign nmt_state_out = nmt_code;
  assign reset_node_out = rn_q;
  assign reset_comm_out = rc_q;
  assign nv_store_out = nvs_q;
  assign nv_store_sel_out = nvsel_q;
  assign nv_store_data_out = nvdat_q;
  assign station_out = node_q;

endmodule : cid_decoder
`default_nettype wire

// ### tb/cid_decoder_properties.sv
`timescale 1ns/1ps
`default_nettype none
module cid_decoder_properties
  import cid_pkg::*;
(
  input wire logic        clk_in,
  input wire logic        srst_in,
  input wire logic        rx_valid_in,
  input wire logic [10:0] rx_id_in,
  input wire logic [63:0] rx_data_in,
  input wire logic        tx_valid_out,
  input wire logic        tx_ready_in,
  input wire logic [10:0] tx_id_out,
  input wire logic [3:0]  tx_dlc_out,
  input wire logic [63:0] tx_data_out,
  input wire logic [1:0]  tpdo_map_sel_in,
  input wire logic        map_fault_out,
  input wire logic        rpdo_valid_out,
  input wire logic [63:0] rpdo_data_out,
  input wire logic        sync_pulse_out,
  input wire logic        time_pulse_out,
  input wire logic [1:0]  nmt_state_out,
  input wire logic [6:0]  station_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (srst_in);

  property p_sync;
    rx_valid_in && rx_id_in == 11'h080 |=> sync_pulse_out;
  endproperty
  a_sync: assert property (p_sync) else $error("sync pulse missing");
  property p_sync_cause;
    sync_pulse_out |-> $past(rx_valid_in) && $past(rx_id_in) == 11'h080;
  endproperty
  a_sync_cause: assert property (p_sync_cause) else $error("sync pulse without cause");
  property p_time;
    rx_valid_in && rx_id_in == 11'h100 |=> time_pulse_out;
  endproperty
  a_time: assert property (p_time) else $error("time pulse missing");
  property p_hold;
    tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_id_out) && $stable(tx_data_out);
  endproperty
  a_hold: assert property (p_hold) else $error("offered frame changed");
  property p_node;
    tx_valid_out |-> tx_id_out[6:0] == station_out && station_out != NODE_NONE;
  endproperty
  a_node: assert property (p_node) else $error("frame not on own node");
  property p_fc;
    tx_valid_out |-> (tx_id_out[10:7] == FC_SDO_TX && tx_dlc_out == SDO_DLC)
      || (tx_id_out[10:7] == FC_TPDO1 && tx_dlc_out == TPDO_DLC);
  endproperty
  a_fc: assert property (p_fc) else $error("bad function code on frame");
  property p_rpdo;
    rx_valid_in && rx_id_in == {FC_RPDO1, station_out} && station_out != NODE_NONE
      && nmt_state_out == ST_OPER |=> rpdo_valid_out && rpdo_data_out == $past(rx_data_in);
  endproperty
  a_rpdo: assert property (p_rpdo) else $error("process data not passed raw");
  property p_other;
    rx_valid_in && rx_id_in[10:7] == FC_RPDO1 && rx_id_in[6:0] != station_out |=> !rpdo_valid_out;
  endproperty
  a_other: assert property (p_other) else $error("foreign node frame taken");
  property p_map;
    map_fault_out == !OBJ_MAP[tpdo_map_sel_in];
  endproperty
  a_map: assert property (p_map) else $error("mapping fault wrong");
  property p_nmt;
    rx_valid_in && rx_id_in == 11'h000 && rx_data_in[7:0] == NMT_START
      && (rx_data_in[15:8] == 8'h00 || rx_data_in[15:8] == {1'b0, station_out}) |=> nmt_state_out == ST_OPER;
  endproperty
  a_nmt: assert property (p_nmt) else $error("start command not obeyed");

  c_sync: cover property (sync_pulse_out);
  c_rpdo: cover property (rpdo_valid_out);
  c_accept: cover property (tx_valid_out && tx_ready_in);
endmodule : cid_decoder_properties

bind cid_decoder cid_decoder_properties u_cid_decoder_properties (
  .clk_in(clk_in), .srst_in(srst_in), .rx_valid_in(rx_valid_in), .rx_id_in(rx_id_in),
  .rx_data_in(rx_data_in), .tx_valid_out(tx_valid_out), .tx_ready_in(tx_ready_in),
  .tx_id_out(tx_id_out), .tx_dlc_out(tx_dlc_out), .tx_data_out(tx_data_out),
  .tpdo_map_sel_in(tpdo_map_sel_in), .map_fault_out(map_fault_out), .rpdo_valid_out(rpdo_valid_out),
  .rpdo_data_out(rpdo_data_out), .sync_pulse_out(sync_pulse_out), .time_pulse_out(time_pulse_out),
  .nmt_state_out(nmt_state_out), .station_out(station_out)
);
`default_nettype wire

// ### tb/cid_can_master.sv
`timescale 1ns/1ps
`default_nettype none
module cid_can_master
  import cid_pkg::*;
(
  input  wire logic        clk_in,
  output logic             rx_valid_out,
  output logic [10:0]      rx_id_out,
  output logic [3:0]       rx_dlc_out,
  output logic [63:0]      rx_data_out,
  input  wire logic        tx_valid_in,
  input  wire logic [10:0] tx_id_in,
  input  wire logic [63:0] tx_data_in,
  input  wire logic [3:0]  tx_dlc_in,
  output logic             tx_ready_out
);
  initial
  begin
    rx_valid_out = 1'b0;
    rx_id_out = 11'h7ff;
    rx_dlc_out = 4'hf;
    rx_data_out = 64'h0;
    tx_ready_out = 1'b0;
  end

  // Lines are inverted after a frame so that a stale frame never looks valid. Nothing waits for a reply here.
  task automatic send(input logic [10:0] id, input logic [3:0] dlc, input logic [63:0] data);
    @(posedge clk_in);
    rx_valid_out <= 1'b1;
    rx_id_out <= id;
    rx_dlc_out <= dlc;
    rx_data_out <= data;
    @(posedge clk_in);
    rx_valid_out <= 1'b0;
    rx_id_out <= ~id;
    rx_dlc_out <= ~dlc;
    rx_data_out <= ~data;
  endtask : send

  task automatic sdo(input logic [6:0] node, input logic [7:0] cmd, input logic [15:0] idx, input logic [31:0] val);
    send({FC_SDO_RX, node}, SDO_DLC, {val, OBJ_SUB, idx, cmd});
  endtask : sdo

  task automatic take(input int slow, output logic [10:0] id, output logic [3:0] dlc, output logic [63:0] data,
                      output bit got);
    got = 1'b0;
    for (int i = 0; i < 20 && !got; i++)
    begin
      @(negedge clk_in);
      got = (tx_valid_in === 1'b1);
    end
    id = tx_id_in;
    dlc = tx_dlc_in;
    data = tx_data_in;
    if (got)
    begin
      repeat (slow) @(posedge clk_in);
      tx_ready_out <= 1'b1;
      @(posedge clk_in);
      tx_ready_out <= 1'b0;
    end
  endtask : take
endmodule : cid_can_master
`default_nettype wire

// ### tb/cid_decoder_tb.sv
`timescale 1ns/1ps
`default_nettype none
module cid_decoder_tb import cid_pkg::*;;
  logic        clk_in = 1'b0;
  logic        srst_in = 1'b1;
  logic [1:0]  sel = 2'h1;
  logic        rx_valid, tx_valid, tx_ready, map_fault, rpdo_valid, sync_pulse, time_pulse;
  logic [10:0] rx_id, tx_id;
  logic [3:0]  rx_dlc, tx_dlc, rpdo_dlc;
  logic [63:0] rx_data, tx_data, rpdo_data;
  logic [15:0] ctrl_word;
  logic [7:0]  mode_sel;
  logic [1:0]  nmt_state;
  logic [6:0]  station;
  logic        reset_node, reset_comm, nv_store;
  logic [31:0] target_pos;
  int          failures = 0;
  int          comparisons = 0;
  localparam logic [15:0] DSTAT = 16'h5a5c;

  always #12.5 clk_in = ~clk_in;

  cid_decoder u_cid_decoder (.clk_in(clk_in), .srst_in(srst_in), .station_in(7'h01), .rx_valid_in(rx_valid),
    .rx_id_in(rx_id), .rx_dlc_in(rx_dlc), .rx_data_in(rx_data), .tx_valid_out(tx_valid), .tx_id_out(tx_id),
    .tx_dlc_out(tx_dlc), .tx_data_out(tx_data), .tx_ready_in(tx_ready), .drive_status_in(DSTAT),
    .tpdo_map_sel_in(sel), .map_fault_out(map_fault), .drive_control_word_out(ctrl_word),
    .operating_mode_select_out(mode_sel), .target_position_value_out(target_pos), .rpdo_valid_out(rpdo_valid),
    .rpdo_dlc_out(rpdo_dlc), .rpdo_data_out(rpdo_data), .sync_pulse_out(sync_pulse),
    .time_pulse_out(time_pulse), .nmt_state_out(nmt_state), .reset_node_out(reset_node),
    .reset_comm_out(reset_comm), .nv_store_out(nv_store), .nv_store_sel_out(), .nv_store_data_out(),
    .station_out(station));

  cid_can_master u_cid_can_master (.clk_in(clk_in), .rx_valid_out(rx_valid), .rx_id_out(rx_id),
    .rx_dlc_out(rx_dlc), .rx_data_out(rx_data), .tx_valid_in(tx_valid), .tx_id_in(tx_id),
    .tx_data_in(tx_data), .tx_dlc_in(tx_dlc), .tx_ready_out(tx_ready));

  task automatic chk_val(input logic [63:0] got, input logic [63:0] exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk_val

  // A missing frame counts once; the field compares run only when a wanted frame was taken.
  task automatic chk_frame(input bit want, input logic [10:0] id, input logic [63:0] data, input logic [63:0] mask,
                           input int slow);
    logic [10:0] g_id;
    logic [3:0]  g_dlc;
    logic [63:0] g_data;
    bit          got;
    u_cid_can_master.take(slow, g_id, g_dlc, g_data, got);
    chk_val(64'(got), 64'(want), "frame presence");
    if (want && got)
    begin
      chk_val(64'(g_id), 64'(id), "frame id");
      chk_val(64'(g_dlc), (id[10:7] == FC_TPDO1) ? 64'(TPDO_DLC) : 64'(SDO_DLC), "frame length");
      chk_val(g_data & mask, data & mask, "frame data");
    end
  endtask : chk_frame

  task automatic t_nmt;
    u_cid_can_master.send(11'h000, 4'h2, {48'h0, 8'h02, NMT_START});
    @(negedge clk_in);
    chk_val(64'(nmt_state), 64'(ST_PREOP), "start for other node");
    u_cid_can_master.send(11'h000, 4'h2, {48'h0, 8'h01, NMT_STOP});
    @(negedge clk_in);
    chk_val(64'(nmt_state), 64'(ST_STOP), "stop for own node");
    u_cid_can_master.send(11'h000, 4'h2, {48'h0, 8'h00, NMT_RST_COMM});
    @(negedge clk_in);
    chk_val(64'({reset_comm, reset_node, nmt_state}), 64'({2'b10, ST_PREOP}), "reset communication");
    u_cid_can_master.send(11'h000, 4'h2, {48'h0, 8'h01, NMT_RST_NODE});
    @(negedge clk_in);
    chk_val(64'({reset_comm, reset_node, nmt_state}), 64'({2'b01, ST_PREOP}), "reset node");
    u_cid_can_master.send(11'h000, 4'h2, {48'h0, 8'h00, NMT_START});
    @(negedge clk_in);
    chk_val(64'(nmt_state), 64'(ST_OPER), "start for all nodes");
  endtask : t_nmt

  task automatic t_sdo;
    u_cid_can_master.sdo(7'h01, CMD_DL1, 16'h6060, 32'h0000_0006);
    chk_frame(1'b1, 11'h581, {32'h0, 8'h00, 16'h6060, RES_DL_OK}, 64'hffff_ffff, 0);
    chk_val(64'(mode_sel), 64'h06, "mode written");
    u_cid_can_master.sdo(7'h01, CMD_DL2, 16'h6040, 32'h1234_002f);
    chk_frame(1'b1, 11'h581, {32'h0, 8'h00, 16'h6040, RES_DL_OK}, 64'hffff_ffff, 3);
    chk_val(64'(ctrl_word), 64'h002f, "control word masked");
    u_cid_can_master.sdo(7'h01, CMD_UL, 16'h6040, 32'h0);
    chk_frame(1'b1, 11'h581, {32'h2f, 8'h00, 16'h6040, RES_UL2}, 64'hffff_ffff_ffff, 5);
    u_cid_can_master.sdo(7'h01, CMD_UL, 16'h6041, 32'h0);
    chk_frame(1'b1, 11'h581, {16'h0, {DSTAT[15:2], ST_OPER}, 8'h00, 16'h6041, RES_UL2}, 64'hffff_ffff_ffff, 0);
    u_cid_can_master.sdo(7'h01, CMD_UL, 16'h607a, 32'h0);
    chk_frame(1'b1, 11'h581, {ABORT_WO, 8'h00, 16'h607a, RES_ERR}, '1, 1);
    u_cid_can_master.sdo(7'h01, CMD_DL2, 16'h6041, 32'h0000_1111);
    chk_frame(1'b1, 11'h581, {ABORT_RO, 8'h00, 16'h6041, RES_ERR}, '1, 0);
    u_cid_can_master.sdo(7'h01, CMD_DL4, 16'h607a, 32'h0000_c350);
    @(negedge clk_in);
    chk_val(64'(nv_store), 64'h0, "no storable object");
    chk_frame(1'b1, 11'h581, {32'h0, 8'h00, 16'h607a, RES_DL_OK}, '1, 0);
    chk_val(64'(target_pos), 64'h0000_c350, "target written");
    u_cid_can_master.sdo(7'h01, 8'h22, 16'h6040, 32'h0);
    chk_frame(1'b1, 11'h581, {ABORT_CMD, 8'h00, 16'h6040, RES_ERR}, '1, 0);
    u_cid_can_master.sdo(7'h01, CMD_UL, 16'h1000, 32'h0);
    chk_frame(1'b1, 11'h581, {ABORT_NO_OBJ, 8'h00, 16'h1000, RES_ERR}, '1, 0);
    u_cid_can_master.sdo(7'h02, CMD_UL, 16'h6040, 32'h0);
    chk_frame(1'b0, 11'h000, 64'h0, 64'h0, 0);
  endtask : t_sdo

  task automatic t_pdo;
    u_cid_can_master.send(11'h201, 4'h8, 64'h8877_6655_4433_2211);
    @(negedge clk_in);
    chk_val(64'(rpdo_valid), 64'h1, "receive pdo pulse");
    chk_val(rpdo_data, 64'h8877_6655_4433_2211, "receive pdo data");
    chk_val(64'(rpdo_dlc), 64'h8, "receive pdo length");
    u_cid_can_master.send(11'h202, 4'h8, 64'h1);
    @(negedge clk_in);
    chk_val(64'(rpdo_valid), 64'h0, "foreign pdo");
    u_cid_can_master.send(11'h080, 4'h0, 64'h0);
    @(negedge clk_in);
    chk_val(64'(sync_pulse), 64'h1, "sync pulse");
    chk_frame(1'b1, 11'h181, 64'({DSTAT[15:2], ST_OPER}), 64'hffff, 0);
    // The first reply blocks the slot, so a second reply and a process-data frame queue up behind it.
    u_cid_can_master.sdo(7'h01, CMD_UL, 16'h6041, 32'h0);
    u_cid_can_master.sdo(7'h01, CMD_UL, 16'h6060, 32'h0);
    u_cid_can_master.send(11'h080, 4'h0, 64'h0);
    chk_frame(1'b1, 11'h581, {16'h0, {DSTAT[15:2], ST_OPER}, 8'h00, 16'h6041, RES_UL2}, '1, 0);
    chk_frame(1'b1, 11'h181, 64'({DSTAT[15:2], ST_OPER}), 64'hffff, 0);
    chk_frame(1'b1, 11'h581, {32'h06, 8'h00, 16'h6060, RES_UL1}, '1, 0);
    sel <= 2'h0;
    u_cid_can_master.send(11'h080, 4'h0, 64'h0);
    @(negedge clk_in);
    chk_val(64'(map_fault), 64'h1, "unmappable selection");
    chk_frame(1'b0, 11'h000, 64'h0, 64'h0, 0);
    u_cid_can_master.send(11'h100, 4'h6, 64'h0);
    @(negedge clk_in);
    chk_val(64'(time_pulse), 64'h1, "time pulse");
  endtask : t_pdo

  task automatic print_verdict;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : print_verdict

  initial
  begin
    repeat (5) @(posedge clk_in);
    @(negedge clk_in);
    chk_val(64'({tx_valid, nmt_state, station}), 64'h0, "reset outputs");
    @(posedge clk_in);
    srst_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    @(negedge clk_in);
    chk_val(64'(station), 64'h01, "station taken");
    t_nmt();
    t_sdo();
    t_pdo();
    print_verdict();
  end
endmodule : cid_decoder_tb
`default_nettype wire
